// ===== tfc_defs.svh
`ifndef TFC_DEFS_SVH
`define TFC_DEFS_SVH

// queue geometry
`define TFC_DEPTH 8
`define TFC_CNT_W 4
`define TFC_PTR_W 3
// word layout
`define TFC_ADDR_W 16
`define TFC_DATA_W 8
`define TFC_XINFO_W 8
// branch source correction: prior address minus this
`define TFC_BRANCH_ADJ 16'h0002
// reset values
`define TFC_ZERO_WORD 16'h0000
`define TFC_ZERO_BYTE 8'h00
`define TFC_ZERO_CNT 4'h0

`endif

// ===== tfc_pkg.sv
package tfc_pkg;
	// capture sequencer states
	typedef enum logic [1:0] {
		TFC_IDLE,
		TFC_WAIT_TRIG,
		TFC_CAPTURE
	} tfc_state_t;

	// core change-of-flow and bus view
	typedef struct packed {
		logic cofDest;
		logic cofBranch;
		logic [15:0] addr;
		logic [7:0] data;
	} tfc_core_t;

	// one queue entry as presented to the reader
	typedef struct packed {
		logic [15:0] word;
		logic [7:0] xinfo;
	} tfc_entry_t;
endpackage : tfc_pkg

// ===== tfc_entry_reg.sv
`include "tfc_defs.svh"

// one storage slot of the queue
module tfc_entry_reg (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write side
	input wire logic wrEn,
	input wire tfc_pkg::tfc_entry_t wrData,
	// stored value
	output tfc_pkg::tfc_entry_t slot
);
	tfc_pkg::tfc_entry_t slot_q;

	// hold until overwritten
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			slot_q <= '0;
		end else if (wrEn) begin
			slot_q <= wrData;
		end
	end

	assign slot = slot_q;
endmodule : tfc_entry_reg

// ===== tfc_word_mux.sv
`include "tfc_defs.svh"

// builds the word to store from the core buses and mode
module tfc_word_mux (
	// mode
	input wire logic eventOnly,
	// core view
	input wire tfc_pkg::tfc_core_t core,
	input wire logic [15:0] prevAddr,
	input wire logic [7:0] eventData,
	input wire logic [7:0] xinfoIn,
	// result
	output tfc_pkg::tfc_entry_t entry
);
	logic [15:0] branchSrc;
	logic [15:0] cofWord;

	// taken branch records its own source, prior address less two
	assign branchSrc = prevAddr - `TFC_BRANCH_ADJ; // [RULE7]
	assign cofWord = core.cofDest ? core.addr : branchSrc; // [RULE5] [RULE6]
	// event modes keep only the data byte, upper bytes forced zero
	assign entry.word = eventOnly ? {`TFC_ZERO_BYTE, eventData} : cofWord; // [RULE2] [RULE3] [RULE4]
	assign entry.xinfo = eventOnly ? `TFC_ZERO_BYTE : xinfoIn; // [RULE4]
endmodule : tfc_word_mux

// ===== trace_fifo_capture.sv
// Overview of operation
// RULE1: queue holds eight entries, written in capture order.
// RULE2: outside event-only modes entries are change-of-flow addresses.
// RULE3: event-only modes store only the triggering event's data byte.
// RULE4: event-only reads give zero upper byte and zero extended byte.
// RULE5: destination-type change of flow stores current core address.
// RULE6: taken conditional branch records the branch source address.
// RULE7: branch entry is previous-cycle address minus two.
// RULE8: begin mode stores nothing before trigger; allowed in every mode.
// RULE9: after begin trigger stay armed until eight words stored.
// RULE10: end-trigger is unavailable with event-only modes.
// RULE11: end mode stores change-of-flow entries continuously until trigger.
// RULE12: end trigger clears arm and armed flag, stops storing.
// RULE13: end-trigger landing on change-of-flow is itself stored.
// RULE14: host reads only while enabled and disarmed.
// RULE15: entries return oldest first.
// RULE16: with break request disabled, breakpoint type is ignored.
// RULE17: host should match opcode qualify select to breakpoint type.
// RULE18: mismatched end settings: tag late after stop, force early; here both come at the stop, the tag only on a fetched trigger.
// RULE19: host should not choose tag type in begin runs.
// RULE20: begin runs raise break request when queue becomes full.
// RULE21: valid entry count kept, decremented per host read.
`include "tfc_defs.svh"

module trace_fifo_capture #(
	parameter int DEPTH = `TFC_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control bits
	input wire logic traceUnitEnable,
	input wire logic armSet,
	input wire logic armClear,
	input wire logic beginMode,
	input wire logic eventOnly,
	input wire logic cpuBreakRequestEnable,
	input wire logic breakTagType,
	input wire logic opcodeQualifySelect,
	// trigger from comparators (same clock)
	input wire logic trigger,
	input wire logic trigOnFetch,
	// core buses
	input wire tfc_pkg::tfc_core_t core,
	input wire logic [7:0] coreXinfo,
	// host read port
	input wire logic readReq,
	output tfc_pkg::tfc_entry_t readData,
	output logic readValid,
	// status
	output logic armControl,
	output logic armedFlag,
	output logic [3:0] validEntryCount,
	output logic breakForce,
	output logic breakTag
);
	// depth is fixed by the pointer and count widths below
	if (DEPTH != `TFC_DEPTH) begin : g_depthChk
		$error("trace queue depth must be eight");
	end

	// sequencer
	tfc_pkg::tfc_state_t state_q, state_d;
	logic arm_q, arm_d;
	logic [3:0] count_q, count_d;
	// address pipeline
	logic [15:0] prevAddr_q;
	// queue pointers and fill level
	logic [2:0] wrPtr_q, wrPtr_d;
	logic [2:0] rdPtr_q, rdPtr_d;
	logic [3:0] fill_q, fill_d;
	// storage
	tfc_pkg::tfc_entry_t newEntry;
	tfc_pkg::tfc_entry_t slots [DEPTH];
	logic [DEPTH-1:0] slotWr;
	// read port
	tfc_pkg::tfc_entry_t readData_q, readData_d;
	tfc_pkg::tfc_entry_t rdSlot;
	logic readValid_q;
	// break request
	logic breakForce_q, breakForce_d;
	logic breakTag_q, breakTag_d;
	logic breakArmed;
	logic breakOnFull;
	logic breakOnStop;
	logic tagOnStop;
	logic endTagOk;

	// control decodes
	logic cofAny;
	logic endMode;
	logic beginRun;
	logic beginTrig;
	logic endTrig;
	logic storeOk;
	logic store;
	logic newRun;
	logic wrapNow;
	logic rdStep;
	logic hostAccess;
	logic doRead;
	logic fullNow;

	assign cofAny = core.cofDest | core.cofBranch;
	// end mode refused when event-only is chosen
	assign endMode = !beginMode && !eventOnly; // [RULE10]
	// every other run fills once and stops, event modes included
	assign beginRun = !endMode;
	assign beginTrig = (state_q == tfc_pkg::TFC_WAIT_TRIG) && trigger;
	assign endTrig = arm_q && endMode && trigger && (state_q == tfc_pkg::TFC_CAPTURE);
	// event modes capture on the event, others on change of flow
	assign storeOk = eventOnly ? trigger : cofAny;
	// begin: store from trigger onward; end: until trigger, trigger on cof kept
	assign store = traceUnitEnable && arm_q && storeOk &&
		((state_q == tfc_pkg::TFC_CAPTURE) || beginTrig); // [RULE8] [RULE11] [RULE13]
	assign hostAccess = traceUnitEnable && !arm_q; // [RULE14]
	assign doRead = hostAccess && readReq && (count_q != `TFC_ZERO_CNT);
	// the eighth store of a fill-once run is the last
	assign fullNow = beginRun && store && (fill_q == 4'(DEPTH - 1)); // [RULE9]
	// a fresh arm empties the queue before anything lands
	assign newRun = arm_d && !arm_q;
	// end runs keep the newest eight, so a store into a full queue drops the oldest
	assign wrapNow = store && (fill_q == 4'(DEPTH));
	// breakpoint type only matters when break request is enabled
	assign breakArmed = cpuBreakRequestEnable; // [RULE16]
	// tag type without qualification needs a fetched trigger in the stop cycle, else no tag
	assign endTagOk = breakTagType ? (opcodeQualifySelect || trigOnFetch) : 1'b1; // [RULE18]

	// entry builder
	tfc_word_mux u_mux (
		.eventOnly(eventOnly),
		.core(core),
		.prevAddr(prevAddr_q),
		.eventData(core.data),
		.xinfoIn(coreXinfo),
		.entry(newEntry)
	);

	// eight storage slots, one-hot write at the write pointer
	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		assign slotWr[i] = store && (wrPtr_q == 3'(i)); // [RULE1]
		tfc_entry_reg u_slot (
			.clk(clk),
			.rst_n(rst_n),
			.wrEn(slotWr[i]),
			.wrData(newEntry),
			.slot(slots[i])
		);
	end

	// sequencer next state
	always_comb begin
		state_d = state_q;
		arm_d = arm_q;
		if (armSet && traceUnitEnable) begin
			arm_d = 1'b1;
		end
		unique case (state_q)
			tfc_pkg::TFC_IDLE: begin
				if (arm_d && !arm_q) begin
					state_d = (beginMode || eventOnly) ? tfc_pkg::TFC_WAIT_TRIG
						: tfc_pkg::TFC_CAPTURE;
				end
			end
			tfc_pkg::TFC_WAIT_TRIG: begin
				if (beginTrig) begin
					state_d = tfc_pkg::TFC_CAPTURE; // [RULE8]
				end
			end
			tfc_pkg::TFC_CAPTURE: begin
				if (endTrig) begin
					arm_d = 1'b0; // [RULE12]
					state_d = tfc_pkg::TFC_IDLE;
				end
			end
			// unused code: fall back to idle and disarm
			default: begin
				state_d = tfc_pkg::TFC_IDLE;
				arm_d = 1'b0;
			end
		endcase
		// begin run stays armed until eight stored
		if (fullNow) begin
			arm_d = 1'b0; // [RULE9]
			state_d = tfc_pkg::TFC_IDLE;
		end
		if (armClear || !traceUnitEnable) begin
			arm_d = 1'b0;
			state_d = tfc_pkg::TFC_IDLE;
		end
	end

	// count: new arm empties queue, stores add, reads drain
	always_comb begin
		count_d = count_q;
		if (arm_d && !arm_q) begin
			count_d = `TFC_ZERO_CNT;
		end else if (store && count_q != 4'(DEPTH)) begin
			count_d = count_q + 4'h1;
		end else if (doRead) begin
			count_d = count_q - 4'h1; // [RULE21]
		end
	end

	// sequencer state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= tfc_pkg::TFC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// arm register, shown on both arm status outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arm_q <= 1'b0;
		end else begin
			arm_q <= arm_d;
		end
	end

	// valid entry count register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_q <= `TFC_ZERO_CNT;
		end else begin
			count_q <= count_d; // [RULE21]
		end
	end

	// address pipeline for branch source recovery
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prevAddr_q <= `TFC_ZERO_WORD;
		end else begin
			prevAddr_q <= core.addr; // [RULE7]
		end
	end

	// pointer and fill next values; a wrap moves the oldest mark along
	assign rdStep = wrapNow || doRead;
	assign wrPtr_d = newRun ? 3'h0 : (store ? wrPtr_q + 3'h1 : wrPtr_q); // [RULE1]
	assign rdPtr_d = newRun ? 3'h0 : (rdStep ? rdPtr_q + 3'h1 : rdPtr_q); // [RULE15]
	assign fill_d = newRun ? `TFC_ZERO_CNT : ((store && !wrapNow) ? fill_q + 4'h1 : fill_q);

	// write pointer, next free slot
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_q <= 3'h0;
		end else begin
			wrPtr_q <= wrPtr_d;
		end
	end

	// read pointer, always at the oldest entry
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdPtr_q <= 3'h0;
		end else begin
			rdPtr_q <= rdPtr_d;
		end
	end

	// fill level of the current run
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fill_q <= `TFC_ZERO_CNT;
		end else begin
			fill_q <= fill_d;
		end
	end

	// read data: the slot at the read pointer, taken on an accepted read
	assign rdSlot = slots[rdPtr_q];
	assign readData_d = doRead ? rdSlot : readData_q; // [RULE15]

	// one-cycle valid after an accepted request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readValid_q <= 1'b0;
		end else begin
			readValid_q <= doRead; // [RULE14]
		end
	end

	// data holds until the next accepted read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readData_q <= '0;
		end else begin
			readData_q <= readData_d;
		end
	end

	// cpu break request; begin runs break on full, end runs on stop
	assign breakOnFull = breakArmed && fullNow; // [RULE20]
	// force with qualification lands as stop occurs, a known hazard
	assign breakOnStop = breakArmed && endTrig && !breakTagType; // [RULE18]
	assign tagOnStop = breakArmed && endTrig && breakTagType && endTagOk; // [RULE18]
	assign breakForce_d = breakOnFull || breakOnStop;
	assign breakTag_d = tagOnStop;

	// force pulse, one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			breakForce_q <= 1'b0;
		end else begin
			breakForce_q <= breakForce_d;
		end
	end

	// tag pulse, one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			breakTag_q <= 1'b0;
		end else begin
			breakTag_q <= breakTag_d;
		end
	end

	// status outputs straight from registers
	assign readData = readData_q;
	assign readValid = readValid_q;
	assign armControl = arm_q;
	assign armedFlag = arm_q; // [RULE12]
	assign validEntryCount = count_q;
	assign breakForce = breakForce_q;
	assign breakTag = breakTag_q;
endmodule : trace_fifo_capture

// ===== tfc_core_model.sv
// core and comparator stand-in: one call is one bus cycle
module tfc_core_model (
	// bus clock
	input wire logic clk,
	// core buses and trigger hit
	output tfc_pkg::tfc_core_t core,
	output logic trig
);
	timeunit 1ns;
	timeprecision 100ps;
	// quiet bus until the first call
	initial begin
		core = '0;
		trig = 1'b0;
	end
	// launched off the falling edge so the block samples settled values
	task step(input logic t, input logic d, input logic b, input logic [15:0] a,
		input logic [7:0] v);
		@(negedge clk);
		trig <= t;
		core <= '{d, b, a, v};
	endtask : step
endmodule : tfc_core_model

// ===== tfc_props.sv
// port-level checks on the capture queue
module tfc_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// controls
	input wire logic beginMode,
	input wire logic eventOnly,
	input wire logic cpuBreakRequestEnable,
	input wire logic trigger,
	input wire logic traceUnitEnable,
	input wire logic armSet,
	// reader and status
	input wire logic readReq,
	input wire tfc_pkg::tfc_entry_t readData,
	input wire logic readValid,
	input wire logic armControl,
	input wire logic armedFlag,
	input wire logic [3:0] validEntryCount,
	input wire logic breakForce,
	input wire logic breakTag
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a read the block must accept
	sequence s_rd;
		readReq && traceUnitEnable && !armControl && validEntryCount != 4'h0;
	endsequence
	property p_rdOk; s_rd |=> readValid; endproperty
	a_rdOk: assert property (p_rdOk) else $error("read not answered");
	property p_rdNo; readReq && armControl |=> !readValid; endproperty
	a_rdNo: assert property (p_rdNo) else $error("read while armed");
	property p_cnt; s_rd && !armSet |=> validEntryCount == $past(validEntryCount) - 4'h1;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count not reduced");
	property p_max; validEntryCount <= 4'h8; endproperty
	a_max: assert property (p_max) else $error("count above depth");
	property p_evt; eventOnly && readValid |-> readData.word[15:8] == 8'h00
		&& readData.xinfo == 8'h00; endproperty
	a_evt: assert property (p_evt) else $error("event entry not zero padded");
	property p_stop; armControl && !beginMode && !eventOnly && trigger |=> !armControl;
	endproperty
	a_stop: assert property (p_stop) else $error("end trigger kept arm");
	property p_flag; armControl == armedFlag; endproperty
	a_flag: assert property (p_flag) else $error("arm and flag differ");
	property p_nobrk; !cpuBreakRequestEnable [*2] |-> !breakForce && !breakTag; endproperty
	a_nobrk: assert property (p_nobrk) else $error("break while disabled");
endmodule : tfc_props

// ===== trace_fifo_capture_tb.sv
module trace_fifo_capture_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n, traceUnitEnable, armSet, armClear, beginMode, eventOnly, trigger, readReq;
	logic cpuBreakRequestEnable, breakTagType, opcodeQualifySelect, trigOnFetch;
	logic armControl, armedFlag, readValid, breakForce, breakTag;
	logic [7:0] coreXinfo;
	logic [3:0] validEntryCount;
	tfc_pkg::tfc_core_t core;
	tfc_pkg::tfc_entry_t readData;
	int nMismatch = 0;
	int testsRun = 0;
	int nBrk = 0;
	int nTag = 0;
	trace_fifo_capture i_dut (.clk(clk), .rst_n(rst_n), .traceUnitEnable(traceUnitEnable),
		.armSet(armSet), .armClear(armClear), .beginMode(beginMode), .eventOnly(eventOnly),
		.cpuBreakRequestEnable(cpuBreakRequestEnable), .breakTagType(breakTagType),
		.opcodeQualifySelect(opcodeQualifySelect), .trigger(trigger),
		.trigOnFetch(trigOnFetch), .core(core), .coreXinfo(coreXinfo), .readReq(readReq),
		.readData(readData), .readValid(readValid), .armControl(armControl),
		.armedFlag(armedFlag), .validEntryCount(validEntryCount), .breakForce(breakForce),
		.breakTag(breakTag));
	tfc_core_model i_core (.clk(clk), .core(core), .trig(trigger));
	// 40 MHz bus clock
	always #12.5 clk = ~clk;
	// break pulses seen so far
	always @(posedge clk) if (breakForce === 1'b1 || breakTag === 1'b1) nBrk <= nBrk + 1;
	always @(posedge clk) if (breakTag === 1'b1) nTag <= nTag + 1;
	task chk(input logic c, input string m);
		testsRun++;
		if (c !== 1'b1) begin
			nMismatch++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask : chk
	task close_out;
		$display("checks %0d, mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	task arm(input logic b, input logic ev);
		@(negedge clk);
		beginMode = b;
		eventOnly = ev;
		armSet = 1'b1;
		@(negedge clk);
		armSet = 1'b0;
	endtask : arm
	// host read; refused reads expect no valid pulse
	task rd(input logic v, input logic [15:0] w, input logic [7:0] x);
		@(negedge clk);
		readReq = 1'b1;
		@(negedge clk);
		readReq = 1'b0;
		chk(readValid === v, "read valid");
		if (v) chk(readData.word === w && readData.xinfo === x, "read data");
	endtask : rd
	// idle cycle then a change of flow; odd i is destination, even i a branch
	task cof(input int i, input logic t, output logic [15:0] e);
		logic [15:0] p;
		p = 16'h1000 + 16'(i) * 16'h0010;
		i_core.step(1'b0, 1'b0, 1'b0, p, 8'h00);
		i_core.step(t, i[0], ~i[0], p + 16'h1000, 8'h00);
		e = i[0] ? p + 16'h1000 : p - 16'h0002;
	endtask : cof
	task t_begin;
		logic [15:0] e[8];
		int nb;
		cpuBreakRequestEnable = 1'b1;
		breakTagType = 1'b0;
		arm(1'b1, 1'b0);
		cof(1, 1'b0, e[0]);
		i_core.step(1'b1, 1'b0, 1'b0, 16'h0F00, 8'h00);
		chk(validEntryCount === 4'h0, "stored before trigger");
		nb = nBrk;
		for (int i = 0; i < 8; i++) cof(i, 1'b0, e[i]);
		repeat (3) i_core.step(1'b0, 1'b1, 1'b0, 16'h0F00, 8'h00);
		chk(validEntryCount === 4'h8 && armControl === 1'b0, "full stop");
		chk(nBrk == nb + 1, "break on full");
		for (int i = 0; i < 8; i++) rd(1'b1, e[i], 8'hA5);
		chk(validEntryCount === 4'h0, "count after reads");
		$display("begin capture test done");
	endtask : t_begin
	task t_end;
		logic [15:0] e[11];
		int nb;
		opcodeQualifySelect = breakTagType;
		arm(1'b0, 1'b0);
		nb = nBrk;
		for (int i = 0; i < 10; i++) cof(i, i == 9, e[i]);
		i_core.step(1'b0, 1'b0, 1'b0, 16'h0F00, 8'h00);
		chk(armControl === 1'b0, "end trigger kept arm");
		cof(3, 1'b0, e[10]);
		i_core.step(1'b0, 1'b0, 1'b0, 16'h0F00, 8'h00);
		chk(validEntryCount === 4'h8, "stored after end");
		chk(nBrk == nb + 1, "force break at end stop");
		for (int i = 0; i < 8; i++) rd(1'b1, e[i + 2], 8'hA5);
		// tag type with qualification: tag pulse at the stop, trigger entry kept
		breakTagType = 1'b1;
		opcodeQualifySelect = breakTagType;
		arm(1'b0, 1'b0);
		cof(0, 1'b1, e[0]);
		repeat (2) i_core.step(1'b0, 1'b0, 1'b0, 16'h0F00, 8'h00);
		chk(nTag == 1 && validEntryCount === 4'h1, "tag break at end stop");
		rd(1'b1, e[0], 8'hA5);
		$display("end capture test done");
	endtask : t_end
	task t_event;
		logic [15:0] e;
		int nb;
		cpuBreakRequestEnable = 1'b0;
		breakTagType = 1'b1;
		arm(1'b0, 1'b1);
		cof(1, 1'b0, e);
		rd(1'b0, 16'h0000, 8'h00);
		chk(validEntryCount === 4'h0, "end mode taken");
		nb = nBrk;
		for (int i = 0; i < 8; i++) i_core.step(1'b1, 1'b0, 1'b0, 16'h3000, 8'h40 + 8'(i));
		i_core.step(1'b0, 1'b0, 1'b0, 16'h3000, 8'h00);
		chk(validEntryCount === 4'h8 && nBrk == nb && armControl === 1'b0, "event fill");
		for (int i = 0; i < 8; i++) rd(1'b1, {8'h00, 8'h40 + 8'(i)}, 8'h00);
		// software disarm before any trigger leaves an empty queue
		arm(1'b1, 1'b0);
		@(negedge clk);
		armClear = 1'b1;
		@(negedge clk);
		armClear = 1'b0;
		chk(armControl === 1'b0 && validEntryCount === 4'h0, "software disarm");
		$display("event capture test done");
	endtask : t_event
	// main sequence
	initial begin
		{rst_n, traceUnitEnable, armSet, armClear, beginMode, eventOnly, readReq} = '0;
		{cpuBreakRequestEnable, breakTagType, opcodeQualifySelect, trigOnFetch} = '0;
		coreXinfo = 8'hA5;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		traceUnitEnable = 1'b1;
		t_begin();
		t_end();
		t_event();
		close_out();
	end
	// hang guard, several times the expected run
	initial begin
		#40000;
		nMismatch++;
		close_out();
	end
endmodule : trace_fifo_capture_tb
bind trace_fifo_capture tfc_props i_props (.clk(clk), .rst_n(rst_n), .beginMode(beginMode),
	.eventOnly(eventOnly), .cpuBreakRequestEnable(cpuBreakRequestEnable), .trigger(trigger),
	.traceUnitEnable(traceUnitEnable), .armSet(armSet), .readReq(readReq), .readData(readData),
	.readValid(readValid), .armControl(armControl), .armedFlag(armedFlag),
	.validEntryCount(validEntryCount), .breakForce(breakForce), .breakTag(breakTag));
